// ### verilog/pos_sequencer.sv
// Playback output sequencer: marker, direct, station, pattern paths
`timescale 1ns/1ps
// Functional notes
// - marker aligns to first unsuppressed pulse
// - marker high time 240/480/960/1920 cycles
// - frame period is high+low+1 cycles
// - frame counted in clocks, not words
// - external marker delayed to meet first header
// - direct path starts on pulse if run
// - later pulse pauses direct path, drops valid
// - reload pointer, resume valid 90 cycles later
// - second pulse marks first resumed word out
// - pulse with run clear idles direct path
// - drained buffer sends both paths to finished
// - two 240x16 header banks, ping-pong use
// - bank toggles each marker, reset odd
// - toggling continues whenever header store enabled
// - station path starts on pulse after run
// - header words while marker high, RAM otherwise
// - run clear stops at frame end
// - generator emits one pattern word per clock
// - second-tick word raises sums interrupt
// - one bit per second, index latched
// - error weight and signed bias per second
// - interrupt right after enabling checker
// - pulse counts only when suppress clear
module pos_sequencer (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire pos_pkg::pos_axi_req_t s_axi_req,
  output pos_pkg::pos_axi_rsp_t      s_axi_rsp,
  input  wire logic                  pps_in,
  input  wire logic                  ram_finished,
  input  wire pos_pkg::pos_frame_data_ram_t    ram_rdata,
  output logic                       ram_rd,
  output logic                       ptr_load,
  output logic [31:0]                ptr_start,
  output logic [31:0]                out_data,
  output logic                       output_valid_flag,
  output logic                       frame_start_marker,
  output logic                       pipelined_second_pulse,
  output logic                       checker_sums_interrupt
);
  import pos_pkg::*;

  // Module state except the header banks and hdr_q in one record
  typedef struct packed {
    logic aw_hold; logic [11:0] aw_addr; logic w_hold; logic [31:0] w_data;
    logic [3:0] w_strb; logic aw_rdy; logic w_rdy; logic bvalid; logic [1:0] bresp;
    logic ar_rdy; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    logic [31:0] ctrl; logic [31:0] lowt; logic [15:0] adr0; logic [15:0] adr1;
    logic [4:0] bitsel;
    pos_mk_t mstate; logic [31:0] mcnt; logic bank; logic [7:0] hdr_addr;
    logic [15:0] frames; logic mk_p; logic mk_out;
    pos_dir_t dstate; logic [6:0] dcnt; logic ptr_load; logic [1:0] sec_p; logic sec_out;
    pos_su_t sstate; logic gen_on; logic [31:0] gen_word;
    pos_src_t src0; pos_src_t src1; logic rd; logic chk_rd; logic chk_q;
    logic [4:0] chk_idx; logic [31:0] exp; logic [31:0] err_acc; logic [31:0] bias_acc;
    logic [31:0] err_res; logic [31:0] bias_res; logic sums_int;
    logic [31:0] out_data; logic out_valid;
  } pos_state_t;

  pos_state_t  s;              // Registered state
  pos_state_t  next_s;         // Next state
  logic        upps;           // Unsuppressed one-second pulse
  logic        rise;           // Marker enters its high phase
  logic        wr_go;          // Address and data both held
  logic        hdr_we;         // Header store write strobe
  logic [15:0] hdr_q;          // Header word read one cycle late
  logic [10:0] hlen;           // Selected marker high time
  logic        bit_v;          // Checked bit of the incoming word
  logic [15:0] hdr_mem [2][240]; // Bank 0 even frames, bank 1 odd frames

  // Pattern step shared by generator and checker
  function automatic logic [31:0] pos_lfsr(input logic [31:0] x);
    pos_lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Address decode used by both write and read channels
  function automatic logic pos_mapped(input logic [11:0] a);
    unique case (a)
      OFF_CTRL, OFF_LOWT, OFF_ADR0, OFF_ADR1,
      OFF_BSEL, OFF_ERRW, OFF_BIAS, OFF_STAT: pos_mapped = 1'b1;
      default: pos_mapped = (a[11:10] == OFF_HDR_A || a[11:10] == OFF_HDR_B)
                            && a[9:2] <= HDR_LAST;
    endcase
  endfunction

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] pos_strb(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      o[8*i +: 8] = st[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
    pos_strb = o;
  endfunction

  // Source of the word leaving two cycles later
  function automatic pos_src_t pos_src_of(input pos_state_t t);
    if (t.gen_on) begin
      pos_src_of = SRC_GEN;
    end else if (t.sstate == SU_RUN) begin
      pos_src_of = (t.mstate == MK_HIGH) ? SRC_HDR : SRC_RAM;
    end else if (t.dstate == DIR_RUN) begin
      pos_src_of = SRC_RAM;
    end else begin
      pos_src_of = SRC_NONE;
    end
  endfunction

  // Pulse only passes while the suppress bit is clear
  assign upps = pps_in & ~s.ctrl[CB_SUPP];
  assign hlen = 11'(HIGH_BASE << s.ctrl[CB_HSEL +: 2]);

  // Next-state logic for bus, sequencers and datapath
  always_comb begin
    next_s = s;
    rise   = 1'b0;
    bit_v  = 1'b0;
    // Write address and data are taken independently
    if (s.aw_rdy && s_axi_req.awvalid) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_req.awaddr;
    end
    if (s.w_rdy && s_axi_req.wvalid) begin
      next_s.w_hold = 1'b1;
      next_s.w_data = s_axi_req.wdata;
      next_s.w_strb = s_axi_req.wstrb;
    end
    if (s.bvalid && s_axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    wr_go  = s.aw_hold && s.w_hold && !s.bvalid;
    hdr_we = wr_go && s.aw_addr[11:10] != 2'h0 && pos_mapped(s.aw_addr) && &s.w_strb[1:0];
    if (wr_go) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = pos_mapped(s.aw_addr) ? RESP_OK : RESP_ERR;
      unique case (s.aw_addr)
        OFF_CTRL: next_s.ctrl = pos_strb(s.ctrl, s.w_data, s.w_strb);
        OFF_LOWT: next_s.lowt = pos_strb(s.lowt, s.w_data, s.w_strb);
        OFF_ADR0: next_s.adr0 = 16'(pos_strb({16'h0, s.adr0}, s.w_data, s.w_strb));
        OFF_ADR1: next_s.adr1 = 16'(pos_strb({16'h0, s.adr1}, s.w_data, s.w_strb));
        OFF_BSEL: next_s.bitsel = s.w_strb[0] ? s.w_data[4:0] : s.bitsel;
        default: ;
      endcase
    end
    // Read channel; unmapped reads return zero with an error
    if (s.rvalid && s_axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.ar_rdy && s_axi_req.arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = pos_mapped(s_axi_req.araddr) ? RESP_OK : RESP_ERR;
      unique case (s_axi_req.araddr)
        OFF_CTRL: next_s.rdata = s.ctrl;
        OFF_LOWT: next_s.rdata = s.lowt;
        OFF_ADR0: next_s.rdata = {16'h0, s.adr0};
        OFF_ADR1: next_s.rdata = {16'h0, s.adr1};
        OFF_BSEL: next_s.rdata = {27'h0, s.bitsel};
        OFF_ERRW: next_s.rdata = s.err_res;
        OFF_BIAS: next_s.rdata = s.bias_res;
        OFF_STAT: next_s.rdata = {s.frames, 8'h0, s.bank, s.gen_on,
                                  s.sstate, s.dstate, s.mstate};
        default:  next_s.rdata = 32'h0; // Header store is write only
      endcase
    end
    next_s.aw_rdy = !next_s.aw_hold && !next_s.bvalid;
    next_s.w_rdy  = !next_s.w_hold && !next_s.bvalid;
    next_s.ar_rdy = !next_s.rvalid;

    // Marker generator; frame length is in clocks, not words
    if (!s.ctrl[CB_MKEN]) begin
      next_s.mstate = MK_IDLE;
      next_s.frames = 16'h0;
    end else begin
      unique case (s.mstate)
        MK_IDLE: rise = upps;
        MK_HIGH: begin
          if (s.mcnt == 32'h0) begin
            next_s.mstate = MK_LOW;
            next_s.mcnt   = s.lowt; // Low phase lasts lowt+1 cycles
          end else begin
            next_s.mcnt = s.mcnt - 32'h1;
          end
        end
        MK_LOW: begin
          if (s.mcnt == 32'h0) begin
            rise = 1'b1;
          end else begin
            next_s.mcnt = s.mcnt - 32'h1;
          end
        end
      endcase
    end
    if (rise) begin
      next_s.mstate   = MK_HIGH;
      next_s.mcnt     = {21'h0, hlen} - 32'h1;
      next_s.frames   = s.frames + 16'h1;
      next_s.hdr_addr = 8'h0;
      // Bank flips with every marker while CB_HDEN is set, data or not
      next_s.bank     = s.ctrl[CB_HDEN] ? ~s.bank : s.bank;
    end else if (s.mstate == MK_HIGH) begin
      next_s.hdr_addr = (s.hdr_addr == HDR_LAST) ? 8'h0 : s.hdr_addr + 8'h1;
    end
    // Two-stage delay matches the header read and output registers
    next_s.mk_p   = (s.mstate == MK_HIGH);
    next_s.mk_out = s.mk_p;

    // Direct output path
    next_s.ptr_load = 1'b0;
    if (!s.ctrl[CB_DREN]) begin
      next_s.dstate = DIR_IDLE;
    end else begin
      unique case (s.dstate)
        DIR_IDLE: begin
          if (upps && s.ctrl[CB_DRUN]) begin
            next_s.dstate   = DIR_RUN;
            next_s.ptr_load = 1'b1;
          end
        end
        DIR_RUN: begin
          if (ram_finished) begin
            next_s.dstate = DIR_FIN;
          end else if (upps && s.ctrl[CB_DRUN]) begin
            next_s.dstate   = DIR_PAUSE;
            next_s.dcnt     = DIR_PAUSE_LOAD;
            next_s.ptr_load = 1'b1;
          end else if (upps) begin
            next_s.dstate = DIR_IDLE;
          end
        end
        DIR_PAUSE: begin
          if (upps && !s.ctrl[CB_DRUN]) begin
            next_s.dstate = DIR_IDLE;
          end else if (s.dcnt == 7'h0) begin
            next_s.dstate = DIR_RUN;
          end else begin
            next_s.dcnt = s.dcnt - 7'h1;
          end
        end
        DIR_FIN: ;
      endcase
    end
    // Second pulse comes out with the first fresh word
    next_s.sec_p   = {s.sec_p[0], next_s.dstate == DIR_RUN && s.dstate != DIR_RUN};
    next_s.sec_out = s.sec_p[1];

    // Station output path
    if (!s.ctrl[CB_SUEN]) begin
      next_s.sstate = SU_IDLE;
    end else begin
      unique case (s.sstate)
        SU_IDLE: next_s.sstate = s.ctrl[CB_SRUN] ? SU_ARM : SU_IDLE;
        SU_ARM: begin
          if (!s.ctrl[CB_SRUN]) begin
            next_s.sstate = SU_IDLE;
          end else if (upps) begin
            next_s.sstate = SU_RUN;
          end
        end
        SU_RUN: begin
          if (ram_finished) begin
            next_s.sstate = SU_FIN;
          end else if (rise && !s.ctrl[CB_SRUN]) begin
            next_s.sstate = SU_IDLE; // Stops only at a frame boundary
          end
        end
        SU_FIN: ;
      endcase
    end

    // Pattern generator restarts from the seed on its first pulse
    if (!s.ctrl[CB_GNEN]) begin
      next_s.gen_on = 1'b0;
    end else if (upps && !s.gen_on) begin
      next_s.gen_on   = 1'b1;
      next_s.gen_word = PAT_SEED;
    end
    if (s.src1 == SRC_GEN) begin
      next_s.gen_word = pos_lfsr(s.gen_word); // One word every clock
    end

    // Read strobe and source pipeline
    next_s.src0   = pos_src_of(next_s);
    next_s.src1   = s.src0;
    next_s.chk_rd = next_s.ctrl[CB_CKEN];
    next_s.rd     = (next_s.src0 == SRC_RAM) || next_s.chk_rd;
    next_s.chk_q  = s.chk_rd;

    // Output register; station path gives header when marker high, RAM when low
    unique case (s.src1)
      SRC_NONE: begin
        next_s.out_data  = 32'h0;
        next_s.out_valid = 1'b0;
      end
      SRC_GEN: begin
        next_s.out_data  = s.gen_word;
        next_s.out_valid = 1'b1;
      end
      SRC_HDR: begin
        next_s.out_data  = {16'h0, hdr_q};
        next_s.out_valid = 1'b1;
      end
      SRC_RAM: begin
        next_s.out_data  = ram_rdata.data;
        next_s.out_valid = ram_rdata.valid;
      end
    endcase

    // Pattern checker; first stored word carries the tick
    next_s.sums_int = 1'b0;
    if (s.chk_q && ram_rdata.valid) begin
      bit_v = ram_rdata.data[s.chk_idx];
      if (ram_rdata.second_tick_word) begin
        next_s.sums_int = 1'b1;
        next_s.err_res  = s.err_acc;
        next_s.bias_res = s.bias_acc;
        next_s.chk_idx  = s.bitsel;
        next_s.err_acc  = 32'h0;
        next_s.bias_acc = 32'h0;
        next_s.exp      = pos_lfsr(ram_rdata.data);
      end else begin
        next_s.err_acc  = s.err_acc + {31'h0, bit_v != s.exp[s.chk_idx]};
        next_s.bias_acc = bit_v ? s.bias_acc + 32'h1 : s.bias_acc - 32'h1;
        next_s.exp      = pos_lfsr(s.exp);
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s        <= '0;
      s.ctrl   <= CTRL_RST;
      s.lowt   <= LOWT_RST;
      s.adr0   <= ADR_RST;
      s.adr1   <= ADR_RST;
      s.bitsel <= BSEL_RST;
      s.bank   <= 1'b1; // Odd bank, so the first marker picks even
      s.aw_rdy <= 1'b1;
      s.w_rdy  <= 1'b1;
      s.ar_rdy <= 1'b1;
      s.gen_word <= PAT_SEED;
    end else begin
      s <= next_s;
    end
  end

  // Header banks: software writes, station path reads the other
  always_ff @(posedge mclk) begin
    if (hdr_we) begin
      hdr_mem[s.aw_addr[11]][s.aw_addr[9:2]] <= s.w_data[15:0];
    end
    hdr_q <= hdr_mem[s.bank][s.hdr_addr];
  end

  // Ports straight from flip-flops
  assign s_axi_rsp = '{awready: s.aw_rdy, wready: s.w_rdy, bvalid: s.bvalid,
                       bresp: s.bresp, arready: s.ar_rdy, rvalid: s.rvalid,
                       rdata: s.rdata, rresp: s.rresp};
  assign ram_rd                 = s.rd;
  assign ptr_load               = s.ptr_load;
  assign ptr_start              = {s.adr1, s.adr0};
  assign out_data               = s.out_data;
  assign output_valid_flag      = s.out_valid;
  assign frame_start_marker     = s.mk_out;
  assign pipelined_second_pulse = s.sec_out;
  assign checker_sums_interrupt = s.sums_int;

  // Helper logic watched only by the checks below
  logic        mk_hi;
  logic        mk_hi_d;
  logic        d_run;
  logic        seen;
  logic [31:0] hc;
  logic [31:0] pc;
  assign mk_hi = (s.mstate == MK_HIGH);
  assign d_run = (s.dstate == DIR_RUN);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mk_hi_d <= 1'b0;
      seen    <= 1'b0;
      hc      <= 32'h0;
      pc      <= 32'h0;
    end else begin
      mk_hi_d <= mk_hi;
      seen    <= seen | (mk_hi && !mk_hi_d);
      hc      <= mk_hi ? hc + 32'h1 : 32'h0;
      pc      <= (mk_hi && !mk_hi_d) ? 32'h1 : pc + 32'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_align;
    s.mstate == MK_IDLE && s.ctrl[CB_MKEN] && upps |=> mk_hi;
  endproperty
  a_align: assert property (p_align) else $error("marker not aligned to pulse");

  property p_high;
    mk_hi_d && s.mstate == MK_LOW && $stable(s.ctrl) |-> hc == {21'h0, hlen};
  endproperty
  a_high: assert property (p_high) else $error("marker high time wrong");

  property p_period;
    mk_hi && $past(s.mstate) == MK_LOW && seen && $stable(s.ctrl) && $stable(s.lowt)
      |-> pc == {21'h0, hlen} + s.lowt + 32'h1;
  endproperty
  a_period: assert property (p_period) else $error("frame period wrong");

  property p_ext;
    frame_start_marker == $past(mk_hi, 2);
  endproperty
  a_ext: assert property (p_ext) else $error("external marker delay wrong");

  property p_resume;
    d_run && s.ctrl[CB_DREN] && s.ctrl[CB_DRUN] && upps && !ram_finished
      |=> ptr_load ##1 !ram_rd || s.chk_rd ##86 ram_rd;
  endproperty
  a_resume: assert property (p_resume) else $error("resume timing wrong");

  property p_sec;
    $rose(d_run) |-> ##2 pipelined_second_pulse;
  endproperty
  a_sec: assert property (p_sec) else $error("second pulse misplaced");

  property p_idle;
    (d_run || s.dstate == DIR_PAUSE) && s.ctrl[CB_DREN] && !s.ctrl[CB_DRUN] && upps
      && !ram_finished |=> s.dstate == DIR_IDLE;
  endproperty
  a_idle: assert property (p_idle) else $error("direct path not idled");

  property p_fin;
    d_run && s.ctrl[CB_DREN] && ram_finished |=> s.dstate == DIR_FIN;
  endproperty
  a_fin: assert property (p_fin) else $error("finished state missed");

  property p_bank;
    mk_hi && !mk_hi_d && s.ctrl[CB_HDEN] && $past(s.ctrl[CB_HDEN]) |-> s.bank != $past(s.bank);
  endproperty
  a_bank: assert property (p_bank) else $error("bank did not toggle");

  property p_int;
    s.chk_q && ram_rdata.valid && ram_rdata.second_tick_word |=> checker_sums_interrupt;
  endproperty
  a_int: assert property (p_int) else $error("sums interrupt missing");

  property p_supp;
    s.ctrl[CB_SUPP] && s.mstate == MK_IDLE |=> s.mstate == MK_IDLE;
  endproperty
  a_supp: assert property (p_supp) else $error("suppressed pulse leaked");

  c_frame: cover property (mk_hi && !mk_hi_d && seen);
  c_resume: cover property (s.dstate == DIR_PAUSE ##1 d_run);
  c_int: cover property (checker_sums_interrupt);
endmodule

// ### verilog/pos_pkg.sv
// Constants and types shared by the playback output sequencer
package pos_pkg;
  // Register byte offsets (12-bit AXI4-Lite address)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_LOWT = 12'h004;
  localparam logic [11:0] OFF_ADR0 = 12'h008;
  localparam logic [11:0] OFF_ADR1 = 12'h00c;
  localparam logic [11:0] OFF_BSEL = 12'h010;
  localparam logic [11:0] OFF_ERRW = 12'h014;
  localparam logic [11:0] OFF_BIAS = 12'h018;
  localparam logic [11:0] OFF_STAT = 12'h01c;
  // Header banks sit in address bits 11:10
  localparam logic [1:0]  OFF_HDR_A = 2'h1;
  localparam logic [1:0]  OFF_HDR_B = 2'h2;
  // Control register bit positions
  localparam int CB_SUPP = 0;
  localparam int CB_MKEN = 1;
  localparam int CB_DREN = 2;
  localparam int CB_DRUN = 3;
  localparam int CB_HDEN = 4;
  localparam int CB_SUEN = 5;
  localparam int CB_SRUN = 6;
  localparam int CB_GNEN = 7;
  localparam int CB_CKEN = 8;
  localparam int CB_HSEL = 9;
  // Reset values; pulses start out suppressed
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] LOWT_RST = 32'h0000_0000;
  localparam logic [15:0] ADR_RST  = 16'h0000;
  localparam logic [4:0]  BSEL_RST = 5'h00;
  // Timing and sizes
  localparam logic [10:0] HIGH_BASE      = 11'h0f0;
  localparam logic [7:0]  HDR_LAST       = 8'hef;
  localparam int          DIR_RESUME_CYC = 90;
  localparam int          PIPE_LAT       = 4;
  localparam logic [6:0]  DIR_PAUSE_LOAD = 7'(DIR_RESUME_CYC - PIPE_LAT);
  localparam logic [31:0] PAT_SEED       = 32'h0000_0001;
  localparam logic [1:0]  RESP_OK        = 2'h0;
  localparam logic [1:0]  RESP_ERR       = 2'h2;
  // State encodings
  typedef enum logic [1:0] {MK_IDLE, MK_HIGH, MK_LOW} pos_mk_t;
  typedef enum logic [1:0] {DIR_IDLE, DIR_RUN, DIR_PAUSE, DIR_FIN} pos_dir_t;
  typedef enum logic [1:0] {SU_IDLE, SU_ARM, SU_RUN, SU_FIN} pos_su_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_GEN, SRC_HDR, SRC_RAM} pos_src_t;
  // Word from the frame data RAM
  typedef struct packed {logic second_tick_word; logic valid; logic [31:0] data;} pos_frame_data_ram_t;
  // AXI4-Lite request and response bundles
  typedef struct packed {
    logic awvalid; logic [11:0] awaddr; logic wvalid; logic [31:0] wdata;
    logic [3:0] wstrb; logic bready; logic arvalid; logic [11:0] araddr; logic rready;
  } pos_axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } pos_axi_rsp_t;
endpackage

// ### sim/pos_ram_model.sv
// Frame data RAM model that answers each read strobe one cycle later
`timescale 1ns/1ps
module pos_ram_model
  import pos_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ram_rd,
  input  wire logic        ptr_load,
  input  wire logic [31:0] ptr_start,
  output pos_frame_data_ram_t        ram_rdata
);
  logic [31:0] addr;   // Next location to read
  logic        first;  // Next word carries the second-tick mark
  logic [31:0] cur;    // Location read this cycle
  // A load and a read in one cycle read from the new pointer
  always_comb begin
    cur = ptr_load ? ptr_start : addr;
  end
  // Word data equals its address, so pointer jumps show downstream
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr      <= 32'h0;
      first     <= 1'b1;
      ram_rdata <= '0;
    end else if (ram_rd) begin
      ram_rdata <= '{second_tick_word: first || ptr_load, valid: 1'b1, data: cur};
      addr      <= cur + 32'h1;
      first     <= 1'b0;
    end else begin
      // Released lines never keep the last word
      ram_rdata.valid <= 1'b0;
      ram_rdata.second_tick_word  <= 1'b0;
      ram_rdata.data  <= ~ram_rdata.data;
      if (ptr_load) begin
        addr  <= ptr_start;
        first <= 1'b1;
      end
    end
  end
endmodule

// ### sim/playback_output_sequencer_test.sv
// Self-checking bench for the playback output sequencer
`timescale 1ns/1ps
module playback_output_sequencer_test;
  import pos_pkg::*;
  logic         mclk;
  logic         reset_n;
  pos_axi_req_t req;
  pos_axi_rsp_t rsp;
  logic         pps_in;
  logic         ram_finished;
  pos_frame_data_ram_t    ram_rdata;
  logic         ram_rd;
  logic         ptr_load;
  logic [31:0]  ptr_start;
  logic [31:0]  out_data;
  logic         valid;
  logic         marker;
  logic         spulse;
  logic         sums_int;
  int           n_errors;
  int           samples_checked;
  pos_sequencer uut (.mclk(mclk), .reset_n(reset_n), .s_axi_req(req), .s_axi_rsp(rsp),
    .pps_in(pps_in), .ram_finished(ram_finished), .ram_rdata(ram_rdata), .ram_rd(ram_rd),
    .ptr_load(ptr_load), .ptr_start(ptr_start), .out_data(out_data),
    .output_valid_flag(valid), .frame_start_marker(marker),
    .pipelined_second_pulse(spulse), .checker_sums_interrupt(sums_int));
  pos_ram_model ram (.mclk(mclk), .reset_n(reset_n), .ram_rd(ram_rd), .ptr_load(ptr_load),
    .ptr_start(ptr_start), .ram_rdata(ram_rdata));
  // Free-running 250 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Single comparison point; unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Write one register; each channel released when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask
  // Read one register and its response code
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  // One-cycle second pulse; returns at the edge that samples it
  task automatic pulse();
    @(posedge mclk);
    pps_in <= 1'b1;
    @(posedge mclk);
    pps_in <= 1'b0;
  endtask
  // Counts edges until output 0 marker, 1 valid, 2 interrupt shows lv
  task automatic wait_lvl(input int s, input logic lv, output int n);
    logic v;
    for (n = 1; n < 3000; n++) begin
      @(posedge mclk);
      v = (s == 0) ? marker : (s == 1) ? valid : sums_int;
      if (v === lv) break;
    end
    if (n == 3000) n_errors++;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(OFF_CTRL, d, r);
    check(d, CTRL_RST);
    axi_rd(12'h020, d, r);
    check({d[29:0], r}, {30'h0, RESP_ERR});
    axi_wr(OFF_LOWT, 32'h00ab_cdef);
    axi_rd(OFF_LOWT, d, r);
    check(d, 32'h00ab_cdef);
  endtask
  task automatic t_checker();
    int n;
    axi_wr(OFF_CTRL, 32'h1 | (32'h1 << CB_CKEN));
    wait_lvl(2, 1'b1, n);
    check(32'(n < 40), 32'h1);
    axi_wr(OFF_CTRL, 32'h1);
  endtask
  task automatic t_marker();
    int n;
    int h;
    int l;
    axi_wr(OFF_LOWT, 32'h14);
    for (int s = 0; s < 4; s++) begin
      axi_wr(OFF_CTRL, 32'h1);
      axi_wr(OFF_CTRL, 32'h1 | (32'h1 << CB_MKEN) | (32'(s) << CB_HSEL));
      pulse();
      repeat (40) @(posedge mclk);
      check(32'(marker), 32'h0);
      axi_wr(OFF_CTRL, (32'h1 << CB_MKEN) | (32'(s) << CB_HSEL));
      pulse();
      wait_lvl(0, 1'b1, n);
      check(32'(n), 32'h3);
      wait_lvl(0, 1'b0, h);
      check(32'(h), 32'(HIGH_BASE) << s);
      wait_lvl(0, 1'b1, l);
      check(32'(l), 32'h15);
    end
    axi_wr(OFF_CTRL, 32'h1);
  endtask
  // Station path: header while marker high, frame data after, stop at frame end
  task automatic t_station();
    int          n;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr({OFF_HDR_A, 10'h000}, 32'h0000_5a5a);
    axi_wr({OFF_HDR_A, 10'h004}, 32'h0000_3c3c);
    axi_wr(OFF_CTRL, (32'h1 << CB_MKEN) | (32'h1 << CB_HDEN) | (32'h1 << CB_SUEN)
           | (32'h1 << CB_SRUN));
    pulse();
    wait_lvl(0, 1'b1, n);
    check(32'(n), 32'h3);
    check(out_data, 32'h0000_5a5a);
    @(posedge mclk);
    check(out_data, 32'h0000_3c3c);
    axi_rd(OFF_STAT, d, r);
    check(32'(d[7]), 32'h0);
    wait_lvl(0, 1'b0, n);
    repeat (4) @(posedge mclk);
    check(32'(valid), 32'h1);
    axi_wr(OFF_CTRL, (32'h1 << CB_MKEN) | (32'h1 << CB_HDEN) | (32'h1 << CB_SUEN));
    wait_lvl(0, 1'b1, n);
    check(32'(valid), 32'h0);
    axi_rd(OFF_STAT, d, r);
    check(32'(d[7]), 32'h1);
    axi_wr(OFF_CTRL, 32'h1);
  endtask
  // Generator: seed word first, then one step every clock
  task automatic t_gen();
    int n;
    axi_wr(OFF_CTRL, 32'h1 << CB_GNEN);
    pulse();
    wait_lvl(1, 1'b1, n);
    check(32'(n), 32'h3);
    check(out_data, 32'h0000_0001);
    @(posedge mclk);
    check(out_data, 32'h0000_0003);
    axi_wr(OFF_CTRL, 32'h1);
  endtask
  task automatic t_direct();
    int n;
    axi_wr(OFF_ADR0, 32'h40);
    axi_wr(OFF_ADR1, 32'h0);
    axi_wr(OFF_CTRL, (32'h1 << CB_DREN) | (32'h1 << CB_DRUN));
    pulse();
    wait_lvl(1, 1'b1, n);
    check(32'(n), 32'h3);
    check(out_data, 32'h40);
    check(32'(spulse), 32'h1);
    axi_wr(OFF_ADR0, 32'h80);
    check(32'(valid), 32'h1);
    pulse();
    wait_lvl(1, 1'b0, n);
    check(32'(n), 32'h3);
    wait_lvl(1, 1'b1, n);
    check(32'(n), 32'h57);
    check(out_data, 32'h80);
    check(32'(spulse), 32'h1);
    axi_wr(OFF_CTRL, 32'h1 << CB_DREN);
    pulse();
    repeat (10) @(posedge mclk);
    check(32'(valid), 32'h0);
    axi_wr(OFF_CTRL, (32'h1 << CB_DREN) | (32'h1 << CB_DRUN));
    pulse();
    wait_lvl(1, 1'b1, n);
    ram_finished <= 1'b1;
    repeat (20) @(posedge mclk);
    check(32'(valid), 32'h0);
    ram_finished <= 1'b0;
  endtask
  // Reset, then the scenarios in order
  initial begin
    reset_n = 1'b0;
    req = '0;
    pps_in = 1'b0;
    ram_finished = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_checker();
    t_marker();
    t_station();
    t_gen();
    t_direct();
    end_of_test();
  end
  // Watchdog at 20k cycles, several times what the scenarios need
  initial begin
    #80000;
    n_errors++;
    end_of_test();
  end
endmodule
